// file: rvt_pkg.sv
// Purpose: constants, register map and types for ring validation timing
// Assumes: 8-bit registers on a byte-wide plain register port
// Notes: one timer count is one 2 ms tick
package rvt_pkg;
  // ***********************************************************
  // register map
  // ***********************************************************
  localparam logic [7:0] RVT_OFS_CTL_A = 8'h16; // delay low bits, max limit
  localparam logic [7:0] RVT_OFS_CTL_B = 8'h17; // delay hi, timeout, count
  localparam logic [7:0] RVT_OFS_CTL_C = 8'h18; // enable, load value
  localparam logic [7:0] RVT_OFS_STAT = 8'h19; // read-only status
  localparam logic [7:0] RVT_RST_CTL_A = 8'h00;
  localparam logic [7:0] RVT_RST_CTL_B = 8'h2d;
  localparam logic [7:0] RVT_RST_CTL_C = 8'h19;
  localparam logic [7:0] RVT_MASK_CTL_C = 8'hbf; // bit 6 reserved, reads 0
  localparam logic [7:0] RVT_ZERO_BYTE = 8'h00;

  // ***********************************************************
  // timing
  // ***********************************************************
  localparam int RVT_CLK_NS = 10;
  localparam int RVT_TICK_NS = 2000000; // 2.0 ms per timer count
  localparam int RVT_TICK_CYCLES = RVT_TICK_NS / RVT_CLK_NS;
  localparam int RVT_PRE_W = 18;
  localparam int RVT_DELAY_STEP_MS = 256; // per delay code step
  localparam int RVT_TOUT_STEP_MS = 128; // per timeout code step
  localparam int RVT_TICK_MS = 2;
  localparam int RVT_CNT_W = 10;
  localparam logic [RVT_CNT_W-1:0] RVT_DELAY_STEP =
    RVT_CNT_W'(RVT_DELAY_STEP_MS / RVT_TICK_MS);
  localparam logic [RVT_CNT_W-1:0] RVT_TOUT_STEP =
    RVT_CNT_W'(RVT_TOUT_STEP_MS / RVT_TICK_MS);
  localparam logic [3:0] RVT_TOUT_BAD = 4'h0;
  localparam logic [3:0] RVT_TOUT_MIN = 4'h1;

  // ***********************************************************
  // types
  // ***********************************************************
  typedef struct packed {
    logic [2:0] ring_indicate_delay;
    logic [5:0] ring_timer_max_limit;
    logic [3:0] ring_end_timeout;
    logic [2:0] ring_confirm_count;
    logic       validation_enable;
    logic [5:0] ring_timer_load;
  } rvt_cfg_t;

  typedef enum logic [1:0] {
    RVT_IDLE  = 2'b00,
    RVT_QUAL  = 2'b01,
    RVT_DELAY = 2'b11,
    RVT_VALID = 2'b10
  } rvt_state_t;
endpackage : rvt_pkg

// file: rvt_ring_validation.sv
// Purpose: qualify ring crossings, delay and time out the valid-ring flag
// Assumes: ring_event_in is asynchronous, one crossing per rising edge
// Notes: registers read back one cycle after the read strobe
//
// Decided for this implementation: the address-and-strobe port.
`timescale 1ns/10ps
// Function
// - valid ring reported after code times 256 ms delay, code 0 none
// - each crossing loads six-bit timer with load value; counts down
// - on next crossing before valid, timer above max limit invalidates ring
// - timer decrements once per nominal 2.0 ms tick
// - max limit sets highest accepted ring frequency, 10% margin
// - ringing ends after code times 128 ms since last crossing, code 0 as 1
module rvt_ring_validation #(
  parameter int TICK_CYCLES = rvt_pkg::RVT_TICK_CYCLES
) (
  input  wire logic       clk_sys_in,
  input  wire logic       reset_in,
  input  wire logic       ring_event_in,
  input  wire logic [7:0] addr_in,
  input  wire logic [7:0] wr_data_in,
  input  wire logic       wr_strobe_in,
  input  wire logic       rd_strobe_in,
  output logic [7:0]      rd_data_out,
  output logic            ring_valid_out,
  output logic            ringing_out
);
  import rvt_pkg::*;

  // ***********************************************************
  // helpers
  // ***********************************************************
  // delay length in ticks for a delay code
  function automatic logic [RVT_CNT_W-1:0] delay_ticks(
    input logic [2:0] code
  );
    delay_ticks = RVT_CNT_W'(code * RVT_DELAY_STEP);
  endfunction : delay_ticks

  // timeout in ticks; the invalid code 0 is run as code 1
  function automatic logic [RVT_CNT_W-1:0] tout_ticks(
    input logic [3:0] code
  );
    logic [3:0] c;
    c = (code == RVT_TOUT_BAD) ? RVT_TOUT_MIN : code;
    tout_ticks = RVT_CNT_W'(c * RVT_TOUT_STEP);
  endfunction : tout_ticks

  // ***********************************************************
  // registers
  // ***********************************************************
  rvt_cfg_t cfg_ff;
  rvt_state_t state_ff;
  rvt_state_t nxt_state;
  logic [7:0] rd_data_ff;
  logic [RVT_PRE_W-1:0] pre_ff;
  logic tick_ff;
  logic [2:0] sync_ff;
  logic event_now;
  logic [5:0] timer_ff;
  logic [RVT_CNT_W-1:0] delay_ff;
  logic [RVT_CNT_W-1:0] tout_ff;
  logic valid_ff;
  logic ringing_ff;
  logic too_fast;
  logic tout_hit;
  logic delay_done;

  // software writes; the timing fields steer the logic below
  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      cfg_ff <= rvt_cfg_t'({RVT_RST_CTL_B[7], RVT_RST_CTL_A[7:6],
                RVT_RST_CTL_A[5:0], RVT_RST_CTL_B[6:0],
                RVT_RST_CTL_C[7], RVT_RST_CTL_C[5:0]});
    end else if (wr_strobe_in) begin
      unique case (addr_in)
        RVT_OFS_CTL_A: begin
          cfg_ff.ring_indicate_delay[1:0] <= wr_data_in[7:6];
          cfg_ff.ring_timer_max_limit <= wr_data_in[5:0];
        end
        RVT_OFS_CTL_B: begin
          cfg_ff.ring_indicate_delay[2] <= wr_data_in[7];
          cfg_ff.ring_end_timeout <= wr_data_in[6:3];
          cfg_ff.ring_confirm_count <= wr_data_in[2:0];
        end
        RVT_OFS_CTL_C: begin
          cfg_ff.validation_enable <= wr_data_in[7];
          cfg_ff.ring_timer_load <= wr_data_in[5:0];
        end
        default: begin
        end
      endcase
    end
  end

  // read data stand only in the cycle after the strobe
  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      rd_data_ff <= RVT_ZERO_BYTE;
    end else if (rd_strobe_in) begin
      unique case (addr_in)
        RVT_OFS_CTL_A: rd_data_ff <= {cfg_ff.ring_indicate_delay[1:0],
                                      cfg_ff.ring_timer_max_limit};
        RVT_OFS_CTL_B: rd_data_ff <= {cfg_ff.ring_indicate_delay[2],
                                      cfg_ff.ring_end_timeout,
                                      cfg_ff.ring_confirm_count};
        RVT_OFS_CTL_C: rd_data_ff <= {cfg_ff.validation_enable, 1'b0,
                                      cfg_ff.ring_timer_load};
        RVT_OFS_STAT: rd_data_ff <= {valid_ff, state_ff, timer_ff[4:0]};
        default: rd_data_ff <= RVT_ZERO_BYTE; // unmapped reads zero
      endcase
    end else begin
      rd_data_ff <= RVT_ZERO_BYTE;
    end
  end

  // ***********************************************************
  // tick and event input
  // ***********************************************************
  // one-cycle enable every 2 ms; parameter lets simulation shorten it
  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      pre_ff <= '0;
      tick_ff <= 1'b0;
    end else if (pre_ff == RVT_PRE_W'(TICK_CYCLES - 1)) begin
      pre_ff <= '0;
      tick_ff <= 1'b1;
    end else begin
      pre_ff <= pre_ff + 1'b1;
      tick_ff <= 1'b0;
    end
  end

  // two stages against metastability, third for edge detection
  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      sync_ff <= 3'b000;
    end else begin
      sync_ff <= {sync_ff[1:0], ring_event_in};
    end
  end

  assign event_now = sync_ff[1] & ~sync_ff[2];

  // ***********************************************************
  // frequency qualification timer
  // ***********************************************************
  // reload on every crossing, else count down and stop at zero
  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      timer_ff <= 6'h00;
    end else if (event_now) begin
      timer_ff <= cfg_ff.ring_timer_load;
    end else if (tick_ff && timer_ff != 6'h00) begin
      timer_ff <= timer_ff - 1'b1;
    end
  end

  // crossing came before load minus limit ticks passed: too fast
  assign too_fast = event_now && state_ff != RVT_IDLE &&
                    timer_ff > cfg_ff.ring_timer_max_limit;

  // ***********************************************************
  // ringing end timeout
  // ***********************************************************
  // restarted by each crossing; expiry ends the ringing
  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      tout_ff <= '0;
    end else if (event_now) begin
      tout_ff <= tout_ticks(cfg_ff.ring_end_timeout);
    end else if (tick_ff && tout_ff != '0) begin
      tout_ff <= tout_ff - 1'b1;
    end
  end

  assign tout_hit = state_ff != RVT_IDLE && !event_now &&
                    tout_ff == '0;

  // ***********************************************************
  // indication delay
  // ***********************************************************
  // loaded when a ring qualifies, counts while waiting to report
  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      delay_ff <= '0;
    end else if (state_ff == RVT_QUAL && nxt_state == RVT_DELAY) begin
      delay_ff <= delay_ticks(cfg_ff.ring_indicate_delay);
    end else if (tick_ff && delay_ff != '0) begin
      delay_ff <= delay_ff - 1'b1;
    end
  end

  assign delay_done = delay_ff == '0;

  // ***********************************************************
  // state machine
  // ***********************************************************
  // timeout first, then invalidation, then progress
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      RVT_IDLE: begin
        if (event_now) begin
          nxt_state = RVT_QUAL;
        end
      end
      RVT_QUAL: begin
        if (tout_hit || too_fast) begin
          nxt_state = RVT_IDLE;
        end else if (event_now) begin
          nxt_state = RVT_DELAY;
        end
      end
      RVT_DELAY: begin
        if (tout_hit || too_fast) begin
          nxt_state = RVT_IDLE;
        end else if (delay_done) begin
          nxt_state = RVT_VALID;
        end
      end
      RVT_VALID: begin
        if (tout_hit) begin
          nxt_state = RVT_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      state_ff <= RVT_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // flags follow the next state so they change with it
  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      valid_ff <= 1'b0;
      ringing_ff <= 1'b0;
    end else begin
      valid_ff <= nxt_state == RVT_VALID;
      ringing_ff <= nxt_state != RVT_IDLE;
    end
  end

  assign rd_data_out = rd_data_ff;
  assign ring_valid_out = valid_ff;
  assign ringing_out = ringing_ff;
endmodule : rvt_ring_validation

// file: rvt_ring_validation_chk.sv
// Purpose: port assertions for ring validation timing
// Assumes: bound to the block, one clock domain
// Notes: timeout bounds allow one tick of phase slack
`timescale 1ns/10ps
module rvt_ring_validation_chk #(
  parameter int TICK_CYCLES = 10
) (
  input wire logic clk_sys_in,
  input wire logic reset_in,
  input wire logic ring_event_in,
  input wire logic [7:0] addr_in,
  input wire logic [7:0] wr_data_in,
  input wire logic wr_strobe_in,
  input wire logic rd_strobe_in,
  input wire logic [7:0] rd_data_out,
  input wire logic ring_valid_out,
  input wire logic ringing_out
);
  // ***********************************************************
  // helpers and assertions
  // ***********************************************************
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (reset_in);
  logic [7:0] b_ff;
  logic [19:0] since_ff;
  logic [3:0] tc;
  int unsigned lo, hi;
  // shadow of the timeout register so bounds follow software
  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) b_ff <= 8'h2d;
    else if (wr_strobe_in && addr_in == 8'h17) b_ff <= wr_data_in;
  end
  // clocks since the last crossing at the pin, saturating
  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) since_ff <= 20'h00000;
    else if ($rose(ring_event_in)) since_ff <= 20'h00000;
    else if (since_ff != 20'hfffff) since_ff <= since_ff + 20'h00001;
  end
  // code 0 runs as 1, so bound it that way
  assign tc = (b_ff[6:3] == 4'h0) ? 4'h1 : b_ff[6:3];
  assign lo = (tc * 64 - 1) * TICK_CYCLES;
  assign hi = (tc * 64 + 1) * TICK_CYCLES + 10;
  sequence rise_s;
    $rose(ringing_out);
  endsequence
  rd_idle_zero_a: assert property (!$past(rd_strobe_in)
    |-> rd_data_out == 8'h00) else $error("read data outside slot");
  reg_b_read_a:
    assert property (rd_strobe_in && addr_in == 8'h17
    |=> rd_data_out == $past(b_ff)) else $error("timeout reg readback");
  valid_in_ring_a:
    assert property (ring_valid_out |-> ringing_out)
    else $error("valid without ringing");
  ring_start_a:
    assert property (rise_s |-> $past(ring_event_in, 3))
    else $error("ringing without crossing");
  valid_start_a:
    assert property ($rose(ring_valid_out) |-> $past(ringing_out, 2))
    else $error("valid before qualify");
  end_drop_a:
    assert property ($fell(ringing_out) |-> !ring_valid_out)
    else $error("valid kept after end");
  tout_early_a:
    assert property ($fell(ring_valid_out) |-> since_ff >= lo)
    else $error("ring ended early");
  tout_late_a:
    assert property (ringing_out |-> since_ff <= hi)
    else $error("ring ended late");
endmodule : rvt_ring_validation_chk

// file: rvt_ring_src.sv
// Purpose: ring detector model, periodic crossing pulses
// Assumes: period in clocks, pulse six clocks wide
// Notes: line rests low while stopped
`timescale 1ns/10ps
module rvt_ring_src (
  input wire logic clk_sys_in,
  input wire logic run_in,
  input wire logic [15:0] period_in,
  output logic ring_event_out
);
  // ***********************************************************
  // crossing generator
  // ***********************************************************
  logic [15:0] cnt_ff;
  // wide pulse so the synchroniser cannot miss it
  always_ff @(posedge clk_sys_in) begin
    if (!run_in) cnt_ff <= 16'h0000;
    else if (cnt_ff + 16'h0001 >= period_in) cnt_ff <= 16'h0000;
    else cnt_ff <= cnt_ff + 16'h0001;
  end
  assign ring_event_out = run_in && (cnt_ff < 16'h0006);
endmodule : rvt_ring_src

// file: rvt_ring_validation_test.sv
// Purpose: self-checking bench for ring validation timing
// Assumes: a tick shortened to 10 clocks
// Notes: rings as table rows, reset and bus cases after
`timescale 1ns/10ps
module rvt_ring_validation_test;
  import rvt_pkg::*;
  // ***********************************************************
  // stimulus and checking
  // ***********************************************************
  localparam int T = 10;
  typedef struct packed {
    logic [2:0] dly;
    logic [3:0] tout;
    logic [15:0] per;
    logic ok;
  } rvt_row_t;
  // last row too fast: 2 ticks apart, minimum gap is 5 ticks
  rvt_row_t rows [6] = '{'{3'h0, 4'h1, 16'h0096, 1'b1},
    '{3'h1, 4'h2, 16'h0096, 1'b1}, '{3'h2, 4'h1, 16'h0096, 1'b1},
    '{3'h7, 4'h1, 16'h0096, 1'b1}, '{3'h0, 4'hf, 16'h0096, 1'b1},
    '{3'h1, 4'h3, 16'h0014, 1'b0}};
  logic clk_sys_in, reset_in, ring_event_in, wr_strobe_in, rd_strobe_in;
  logic [7:0] addr_in, wr_data_in, rd_data_out, b_val;
  logic ring_valid_out, ringing_out, run, seen;
  logic [15:0] per;
  int failures, comparisons, n, e;
  rvt_ring_src src (.clk_sys_in(clk_sys_in), .run_in(run),
    .period_in(per), .ring_event_out(ring_event_in));
  rvt_ring_validation #(.TICK_CYCLES(T)) uut (.clk_sys_in(clk_sys_in),
    .reset_in(reset_in), .ring_event_in(ring_event_in), .addr_in(addr_in),
    .wr_data_in(wr_data_in), .wr_strobe_in(wr_strobe_in),
    .rd_strobe_in(rd_strobe_in), .rd_data_out(rd_data_out),
    .ring_valid_out(ring_valid_out), .ringing_out(ringing_out));
  always #5 clk_sys_in = ~clk_sys_in;
  task automatic check(input logic [15:0] s, input logic [15:0] x,
      input string what);
    comparisons++;
    if (s !== x) begin
      failures++;
      $display("wrong value %s expected %h seen %h", what, x, s);
    end
  endtask : check
  task automatic summarize;
    if (failures == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : summarize
  // sample after the edge's updates have landed
  task automatic step;
    @(posedge clk_sys_in);
    #1;
  endtask : step
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys_in);
    addr_in <= a;
    wr_data_in <= d;
    wr_strobe_in <= 1'b1;
    @(posedge clk_sys_in);
    wr_strobe_in <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] x);
    @(posedge clk_sys_in);
    addr_in <= a;
    rd_strobe_in <= 1'b1;
    @(posedge clk_sys_in);
    rd_strobe_in <= 1'b0;
    #1 check({8'h00, rd_data_out}, {8'h00, x}, "register");
  endtask : rd
  initial begin
    clk_sys_in = 1'b0;
    reset_in = 1'b1;
    {addr_in, wr_data_in, wr_strobe_in, rd_strobe_in, run} = 19'h00000;
    per = 16'h0096;
    repeat (3) @(posedge clk_sys_in);
    reset_in <= 1'b0;
    foreach (rows[i]) begin
      b_val = {rows[i].dly[2], rows[i].tout, 3'h5};
      wr(RVT_OFS_CTL_A, {rows[i].dly[1:0], 6'h14});
      wr(RVT_OFS_CTL_B, b_val);
      wr(RVT_OFS_CTL_C, 8'h99);
      rd(RVT_OFS_CTL_B, b_val);
      @(posedge clk_sys_in);
      per <= rows[i].per;
      run <= 1'b1;
      seen = 1'b0;
      for (n = 0; n < 12000 && !seen; n++) begin
        step();
        seen = (ring_valid_out === 1'b1);
      end
      e = rows[i].per + rows[i].dly * 128 * T;
      if (rows[i].ok && !seen) failures++;
      if (rows[i].ok && !seen) summarize();
      if (rows[i].ok)
        check(16'(n + T >= e && n <= e + 8), 16'h0001, "delay");
      else check(16'(seen), 16'h0000, "too fast");
      @(posedge clk_sys_in);
      run <= 1'b0;
      for (n = 0; n < 12000 && ringing_out !== 1'b0; n++) step();
      if (n >= 12000) failures++;
      if (n >= 12000) summarize();
      e = rows[i].tout * 64 * T;
      if (rows[i].ok)
        check(16'(n + 180 > e && n < e + 25), 16'h0001, "end");
      check({14'h0000, ringing_out, ring_valid_out}, 16'h0000, "end");
    end
    // second reset with a ring in progress; outputs must be low by the next clock edge
    @(posedge clk_sys_in);
    per <= 16'h0096;
    run <= 1'b1;
    for (n = 0; n < 50 && ringing_out !== 1'b1; n++) step();
    check({15'h0000, ringing_out}, 16'h0001, "ring start");
    @(posedge clk_sys_in);
    reset_in <= 1'b1;
    run <= 1'b0;
    step();
    check({14'h0000, ringing_out, ring_valid_out}, 16'h0000, "in reset");
    repeat (2) @(posedge clk_sys_in);
    reset_in <= 1'b0;
    // reset values, idle status and odd addresses
    rd(RVT_OFS_STAT, 8'h00);
    rd(RVT_OFS_CTL_A, 8'h00);
    rd(RVT_OFS_CTL_B, 8'h2d);
    rd(RVT_OFS_CTL_C, 8'h19);
    wr(RVT_OFS_CTL_C, 8'hff);
    rd(RVT_OFS_CTL_C, 8'hbf);
    wr(8'h20, 8'h55);
    rd(8'h20, 8'h00);
    summarize();
  end
endmodule : rvt_ring_validation_test
bind rvt_ring_validation rvt_ring_validation_chk #(.TICK_CYCLES(TICK_CYCLES))
  chk (.clk_sys_in(clk_sys_in), .reset_in(reset_in),
  .ring_event_in(ring_event_in), .addr_in(addr_in), .wr_data_in(wr_data_in),
  .wr_strobe_in(wr_strobe_in), .rd_strobe_in(rd_strobe_in),
  .rd_data_out(rd_data_out), .ring_valid_out(ring_valid_out),
  .ringing_out(ringing_out));
